// >>> pkg/loop_ctrl_regs.svh
// Register offsets, field positions and reset values of the loop control bank
`ifndef LOOP_CTRL_REGS_SVH
`define LOOP_CTRL_REGS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define OFS_FIRST_LOOP_FAST_LOCK   10'h10B
`define OFS_SECOND_LOOP_PUMP       10'h200
`define OFS_SECOND_LOOP_FEEDBACK   10'h201
`define OFS_SECOND_LOOP_CONTROL    10'h202
`define OFS_SECOND_LOOP_OSC        10'h203
`define OFS_SECOND_LOOP_RF_DIV     10'h204

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_FAST_LOCK_EN           7
`define BIT_LOCK_DET_PD            7
`define BIT_CTRL_RESERVED          6
`define BIT_DOUBLER_EN             5
`define BIT_PATH_EN                4
`define BIT_CAL_DIV_RESET          3
`define BIT_REF_VALID_FORCE        2
`define BIT_OSC_MIDSCALE           1
`define BIT_OSC_CAL_START          0
`define BIT_PFD_REF_EDGE           5

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define RST_FAST_LOCK              8'h00
`define RST_PUMP                   8'h00
`define RST_FEEDBACK               8'h00
`define RST_CONTROL                8'h03
`define RST_OSC                    8'h00
`define RST_RF_DIV                 8'h00
`define FB_N_MIN                   8'h10
`define FB_N_MAX                   8'hFF

`endif

// >>> pkg/loop_ctrl_pkg.sv
// Types shared by the loop control register bank
package loop_ctrl_pkg;

    // Second-loop charge pump modes
    typedef enum logic [1:0] {
        PUMP_TRISTATE = 2'h0,
        PUMP_DOWN     = 2'h1,
        PUMP_UP       = 2'h2,
        PUMP_NORMAL   = 2'h3
    } pump_mode_t;

endpackage

// >>> hdl/loop_ctrl_word.sv
// One byte-wide control register with reset value
`timescale 1ns/1ps
module loop_ctrl_word #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic [7:0] wr_keep,
    // Stored value
    output logic      [7:0] value_q
);

    typedef struct packed {
        logic [7:0] value;
    } word_state_t;

    word_state_t state_q;
    word_state_t state_d;

    // Bits in wr_keep hold their reset value whatever is written
    always_comb begin
        state_d = state_q;
        if (wr_en) begin
            state_d.value = (wr_data & ~wr_keep) | (RESET_VALUE & wr_keep);
        end
    end

    // Register the word
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q.value <= RESET_VALUE;
        end else begin
            state_q <= state_d;
        end
    end

    assign value_q = state_q.value;

endmodule

// >>> hdl/pll_loop_control_regs.sv
// Control register bank of the dual-loop clock synthesizer
// Operation
// - Fast-lock register bit 7 enables first-loop fast lock.
// - Fast-lock bits 6..0 set first-loop pump current, about 0.5 uA steps.
// - Eight-bit field sets second-loop pump current, about 3.5 uA steps.
// - Calibration divider ratio is 4B+A; software keeps it legal, 16..255.
// - Control bit 7 set powers down the second-loop lock detector.
// - Control bit 5 set doubles the second-loop reference.
// - Pump mode: tristate, down, up, normal; resets to normal.
// - Oscillator bit 4 routes reference through doubler and predivider.
// - Oscillator bit 3 holds calibration dividers in reset.
// - Bit 2 clear uses first-loop indicator; set forces reference valid.
// - Oscillator bit 1 forces control voltage to midscale.
// - Bit 0 starts calibration, zero resets it; never self-cleared.
`timescale 1ns/1ps
`include "loop_ctrl_regs.svh"
module pll_loop_control_regs
    import loop_ctrl_pkg::*;
#(
    parameter int ADDR_WIDTH = 10
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  resetn,
    // Register port from the serial control interface
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    output logic                       reg_rvalid,
    // First-loop indicator from the oscillator monitor (asynchronous)
    input  wire logic                  osc_indicator,
    // First loop controls
    output logic                       fast_lock_en,
    output logic      [6:0]            fast_lock_pump_current,
    // Second loop controls
    output logic      [7:0]            charge_pump_current,
    output pump_mode_t                 charge_pump_mode,
    output logic      [1:0]            cal_div_a,
    output logic      [5:0]            cal_div_b,
    output logic      [7:0]            cal_div_ratio,
    output logic                       cal_div_ratio_legal,
    output logic                       lock_det_powerdown,
    output logic                       ref_doubler_en,
    output logic                       predivider_path_en,
    output logic                       cal_div_reset,
    output logic                       ref_valid,
    output logic                       osc_midscale,
    output logic                       osc_cal_start,
    output logic                       pfd_ref_falling
);

    // Narrower addresses cannot reach the upper bank, so refuse them at elaboration
    if (ADDR_WIDTH < 10) begin : g_addr_check
        $error("ADDR_WIDTH too small for the register map");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Feedback ratio N = 4B + A; B is 6 bits so the sum fits in 8
    function automatic logic [7:0] fb_ratio(input logic [7:0] word);
        fb_ratio = {word[5:0], 2'b00} + {6'h00, word[7:6]};
    endfunction

    // Legal ratio window and A limit tied to B
    function automatic logic fb_legal(input logic [7:0] word);
        logic [7:0] n;
        logic [1:0] a;
        logic [5:0] b;
        n = fb_ratio(word);
        a = word[7:6];
        b = word[5:0];
        fb_legal = (n >= `FB_N_MIN) && (n <= `FB_N_MAX) && (b >= 6'h04) &&
                   ((b >= 6'h07) || (b == 6'h04 && a <= 2'h1) ||
                    (b != 6'h04 && a <= 2'h2));
    endfunction

    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [9:0] ofs);
        hit = (a == ADDR_WIDTH'(ofs));
    endfunction

    // ****************************************************************
    // Register words
    // ****************************************************************

    logic [7:0] fast_lock_w;
    logic [7:0] pump_w;
    logic [7:0] feedback_w;
    logic [7:0] control_w;
    logic [7:0] osc_w;
    logic [7:0] rf_div_w;

    // Reserved control bit 6 is held at zero against stray writes
    loop_ctrl_word #(.RESET_VALUE(`RST_FAST_LOCK)) u_fast_lock (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (reg_wr && hit(reg_addr, `OFS_FIRST_LOOP_FAST_LOCK)),
        .wr_data (reg_wdata),
        .wr_keep (8'h00),
        .value_q (fast_lock_w)
    );
    loop_ctrl_word #(.RESET_VALUE(`RST_PUMP)) u_pump (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_PUMP)),
        .wr_data (reg_wdata),
        .wr_keep (8'h00),
        .value_q (pump_w)
    );
    loop_ctrl_word #(.RESET_VALUE(`RST_FEEDBACK)) u_feedback (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_FEEDBACK)),
        .wr_data (reg_wdata),
        .wr_keep (8'h00),
        .value_q (feedback_w)
    );
    loop_ctrl_word #(.RESET_VALUE(`RST_CONTROL)) u_control (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_CONTROL)),
        .wr_data (reg_wdata),
        .wr_keep (8'h5C),
        .value_q (control_w)
    );
    loop_ctrl_word #(.RESET_VALUE(`RST_OSC)) u_osc (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_OSC)),
        .wr_data (reg_wdata),
        .wr_keep (8'hE0),
        .value_q (osc_w)
    );
    loop_ctrl_word #(.RESET_VALUE(`RST_RF_DIV)) u_rf_div (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_RF_DIV)),
        .wr_data (reg_wdata),
        .wr_keep (8'hC0),
        .value_q (rf_div_w)
    );

    // ****************************************************************
    // Control outputs and read path
    // ****************************************************************

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic [7:0] rdata;
        logic       rvalid;
        logic       fl_en;
        logic [6:0] fl_cur;
        logic [7:0] cp_cur;
        logic [1:0] cp_mode;
        logic [1:0] div_a;
        logic [5:0] div_b;
        logic [7:0] ratio;
        logic       legal;
        logic       ld_pd;
        logic       dbl;
        logic       path;
        logic       div_rst;
        logic       rvld;
        logic       mid;
        logic       cal;
        logic       fall;
    } bank_state_t;

    bank_state_t st_q;
    bank_state_t st_d;

    // Outputs follow the stored words one cycle later, all from flops
    always_comb begin
        st_d = st_q;
        st_d.sync1   = osc_indicator;
        st_d.sync2   = st_q.sync1;
        st_d.fl_en   = fast_lock_w[`BIT_FAST_LOCK_EN];
        st_d.fl_cur  = fast_lock_w[6:0];
        st_d.cp_cur  = pump_w;
        st_d.div_a   = feedback_w[7:6];
        st_d.div_b   = feedback_w[5:0];
        st_d.ratio   = fb_ratio(feedback_w);
        st_d.legal   = fb_legal(feedback_w);
        st_d.ld_pd   = control_w[`BIT_LOCK_DET_PD];
        st_d.dbl     = control_w[`BIT_DOUBLER_EN];
        st_d.cp_mode = control_w[1:0];
        st_d.path    = osc_w[`BIT_PATH_EN];
        st_d.div_rst = osc_w[`BIT_CAL_DIV_RESET];
        // Override wins; otherwise the synchronised indicator decides
        st_d.rvld    = osc_w[`BIT_REF_VALID_FORCE] | st_q.sync2;
        st_d.mid     = osc_w[`BIT_OSC_MIDSCALE];
        st_d.cal     = osc_w[`BIT_OSC_CAL_START];
        st_d.fall    = rf_div_w[`BIT_PFD_REF_EDGE];
        // Unmapped reads answer zero
        st_d.rvalid  = reg_rd;
        st_d.rdata   = 8'h00;
        if (reg_rd) begin
            if (hit(reg_addr, `OFS_FIRST_LOOP_FAST_LOCK)) begin
                st_d.rdata = fast_lock_w;
            end else if (hit(reg_addr, `OFS_SECOND_LOOP_PUMP)) begin
                st_d.rdata = pump_w;
            end else if (hit(reg_addr, `OFS_SECOND_LOOP_FEEDBACK)) begin
                st_d.rdata = feedback_w;
            end else if (hit(reg_addr, `OFS_SECOND_LOOP_CONTROL)) begin
                st_d.rdata = control_w;
            end else if (hit(reg_addr, `OFS_SECOND_LOOP_OSC)) begin
                st_d.rdata = osc_w;
            end else if (hit(reg_addr, `OFS_SECOND_LOOP_RF_DIV)) begin
                st_d.rdata = rf_div_w;
            end
        end
    end

    // Register all outputs; pump mode resets to normal
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q         <= '0;
            st_q.cp_mode <= 2'h3;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata              = st_q.rdata;
    assign reg_rvalid             = st_q.rvalid;
    assign fast_lock_en           = st_q.fl_en;
    assign fast_lock_pump_current = st_q.fl_cur;
    assign charge_pump_current    = st_q.cp_cur;
    assign charge_pump_mode       = pump_mode_t'(st_q.cp_mode);
    assign cal_div_a              = st_q.div_a;
    assign cal_div_b              = st_q.div_b;
    assign cal_div_ratio          = st_q.ratio;
    assign cal_div_ratio_legal    = st_q.legal;
    assign lock_det_powerdown     = st_q.ld_pd;
    assign ref_doubler_en         = st_q.dbl;
    assign predivider_path_en     = st_q.path;
    assign cal_div_reset          = st_q.div_rst;
    assign ref_valid              = st_q.rvld;
    assign osc_midscale           = st_q.mid;
    assign osc_cal_start          = st_q.cal;
    assign pfd_ref_falling        = st_q.fall;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    AST_FAST_LOCK: assert property (@(posedge clock) disable iff (!resetn)
        reg_wr && hit(reg_addr, `OFS_FIRST_LOOP_FAST_LOCK)
        |-> ##2 fast_lock_en == $past(reg_wdata[7], 2) &&
               fast_lock_pump_current == $past(reg_wdata[6:0], 2))
        else $error("fast lock outputs do not follow write");
    AST_PUMP_CUR: assert property (@(posedge clock) disable iff (!resetn)
        reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_PUMP)
        |-> ##2 charge_pump_current == $past(reg_wdata, 2))
        else $error("pump current does not follow write");
    AST_RATIO: assert property (@(posedge clock) disable iff (!resetn)
        cal_div_ratio == {cal_div_b, 2'b00} + {6'h00, cal_div_a})
        else $error("calibration ratio is not 4B+A");
    AST_LOCK_PD: assert property (@(posedge clock) disable iff (!resetn)
        reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_CONTROL)
        |-> ##2 lock_det_powerdown == $past(reg_wdata[7], 2))
        else $error("lock detector power-down wrong");
    AST_RESERVED: assert property (@(posedge clock) disable iff (!resetn)
        control_w[`BIT_CTRL_RESERVED] == 1'b0)
        else $error("reserved control bit set");
    AST_MODE: assert property (@(posedge clock) disable iff (!resetn)
        reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_CONTROL)
        |-> ##2 charge_pump_mode == pump_mode_t'($past(reg_wdata[1:0], 2)))
        else $error("pump mode does not follow write");
    AST_REF_VALID: assert property (@(posedge clock) disable iff (!resetn)
        osc_w[`BIT_REF_VALID_FORCE] |=> ref_valid)
        else $error("forced reference not valid");
    AST_CAL_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        osc_w[`BIT_OSC_CAL_START] && !(reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_OSC))
        |=> ##1 osc_cal_start)
        else $error("calibration bit cleared itself");
    AST_EDGE: assert property (@(posedge clock) disable iff (!resetn)
        reg_wr && hit(reg_addr, `OFS_SECOND_LOOP_RF_DIV)
        |-> ##2 pfd_ref_falling == $past(reg_wdata[5], 2))
        else $error("reference edge select wrong");

endmodule

// >>> bench/test_pll_loop_control_regs.sv
// Self-checking testbench for the loop control register bank
`timescale 1ns/1ps
`include "loop_ctrl_regs.svh"
module test_pll_loop_control_regs
    import loop_ctrl_pkg::*;
;
    // ****************************************************************
    // Stimulus, design outputs and bookkeeping
    // ****************************************************************
    logic             clock         = 1'b0;
    logic             resetn        = 1'b0;
    logic             reg_wr        = 1'b0;
    logic             reg_rd        = 1'b0;
    logic [9:0]       reg_addr      = 10'h000;
    logic [7:0]       reg_wdata     = 8'h00;
    logic             osc_indicator = 1'b0;
    logic [7:0]       reg_rdata;
    logic             reg_rvalid;
    logic             fast_lock_en;
    logic [6:0]       fast_lock_pump_current;
    logic [7:0]       charge_pump_current;
    pump_mode_t       charge_pump_mode;
    logic [1:0]       cal_div_a;
    logic [5:0]       cal_div_b;
    logic [7:0]       cal_div_ratio;
    logic             cal_div_ratio_legal;
    logic             lock_det_powerdown;
    logic             ref_doubler_en;
    logic             predivider_path_en;
    logic             cal_div_reset;
    logic             ref_valid;
    logic             osc_midscale;
    logic             osc_cal_start;
    logic             pfd_ref_falling;
    int               n_errors      = 0;
    int               checks        = 0;
    logic [7:0]       model [6];
    logic [9:0]       addr_tab [6]  = '{`OFS_FIRST_LOOP_FAST_LOCK, `OFS_SECOND_LOOP_PUMP,
                                        `OFS_SECOND_LOOP_FEEDBACK, `OFS_SECOND_LOOP_CONTROL,
                                        `OFS_SECOND_LOOP_OSC, `OFS_SECOND_LOOP_RF_DIV};
    logic [7:0]       div_tab [8]   = '{8'h44, 8'h84, 8'h85, 8'hC5, 8'hC7, 8'hC3, 8'hFF, 8'h00};
    logic [9:0]       bad_tab [4]   = '{10'h000, 10'h10A, 10'h205, 10'h3FF};
    logic [7:0]       v;
    logic [31:0]      rnd;

    // 100 ns period
    always #50 clock = ~clock;

    pll_loop_control_regs i_dut (
        .clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .osc_indicator(osc_indicator),
        .fast_lock_en(fast_lock_en), .fast_lock_pump_current(fast_lock_pump_current),
        .charge_pump_current(charge_pump_current), .charge_pump_mode(charge_pump_mode),
        .cal_div_a(cal_div_a), .cal_div_b(cal_div_b), .cal_div_ratio(cal_div_ratio),
        .cal_div_ratio_legal(cal_div_ratio_legal), .lock_det_powerdown(lock_det_powerdown),
        .ref_doubler_en(ref_doubler_en), .predivider_path_en(predivider_path_en),
        .cal_div_reset(cal_div_reset), .ref_valid(ref_valid), .osc_midscale(osc_midscale),
        .osc_cal_start(osc_cal_start), .pfd_ref_falling(pfd_ref_falling)
    );

    // ****************************************************************
    // Expectation helpers
    // ****************************************************************
    // Bits that hold state; reserved places always read back zero
    function automatic logic [7:0] mask_fn(input int i);
        case (i)
            3: return 8'hA3;
            4: return 8'h1F;
            5: return 8'h3F;
            default: return 8'hFF;
        endcase
    endfunction

    // Prescaler word limits: total 16..255 and the A limit that depends on B
    function automatic logic ratio_ok(input logic [7:0] w);
        if (w[5:0] < 6'h04) return 1'b0;
        if (w[5:0] == 6'h04) return w[7:6] <= 2'h1;
        if (w[5:0] <= 6'h06) return w[7:6] <= 2'h2;
        return 1'b1;
    endfunction

    // ****************************************************************
    // Reporting and bus cycles
    // ****************************************************************
    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] want, input string what);
        checks++;
        if (got !== want) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic want, input string what);
        checks++;
        if (got !== want) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, want);
        end
    endtask

    // Each cycle starts one edge on, so a strobe is never lowered and raised at once
    task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock); #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock); #1;
        reg_wr = 1'b0;
    endtask

    // Optional write in the same cycle checks that the old value is returned
    task automatic bus_rd(input logic [9:0] a, input logic also_wr, input logic [7:0] d,
                          output logic [7:0] q);
        int n;
        @(posedge clock); #1;
        reg_rd = 1'b1;
        reg_wr = also_wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock); #1;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge clock); #1;
            n++;
        end
        q = reg_rdata;
        if (n == 4) begin
            n_errors++;
            $display("CHECK FAILED at %0t: read answer missing", $time);
            tally_and_finish();
        end
    endtask

    task automatic wr_reg(input int i, input logic [7:0] d);
        logic [7:0] w;
        // Software always leaves the reserved control bit clear
        w = (i == 3) ? (d & 8'hBF) : d;
        bus_wr(addr_tab[i], w);
        model[i] = w & mask_fn(i);
    endtask

    // Three edges cover the two-edge output lag and the indicator synchroniser
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic chk_out();
        cmp_bit(fast_lock_en, model[0][7], "fast lock enable");
        cmp_byte({1'b0, fast_lock_pump_current}, {1'b0, model[0][6:0]}, "fast pump");
        cmp_byte(charge_pump_current, model[1], "pump current");
        cmp_byte({cal_div_a, cal_div_b}, model[2], "divider words");
        cmp_byte(cal_div_ratio, {model[2][5:0], 2'h0} + model[2][7:6], "ratio");
        cmp_bit(cal_div_ratio_legal, ratio_ok(model[2]), "ratio legal");
        cmp_bit(lock_det_powerdown, model[3][7], "lock det pd");
        cmp_bit(ref_doubler_en, model[3][5], "doubler");
        cmp_byte({6'h00, charge_pump_mode}, {6'h00, model[3][1:0]}, "pump mode");
        cmp_bit(predivider_path_en, model[4][4], "path");
        cmp_bit(cal_div_reset, model[4][3], "div reset");
        cmp_bit(ref_valid, model[4][2] | osc_indicator, "ref valid");
        cmp_bit(osc_midscale, model[4][1], "midscale");
        cmp_bit(osc_cal_start, model[4][0], "cal start");
        cmp_bit(pfd_ref_falling, model[5][5], "pfd edge");
    endtask

    task automatic read_all();
        logic [7:0] q;
        for (int i = 0; i < 6; i++) begin
            bus_rd(addr_tab[i], 1'b0, 8'h00, q);
            cmp_byte(q, model[i], "read back");
        end
    endtask

    // Outputs are checked while reset is still held, then reset is let go
    task automatic do_reset();
        @(posedge clock); #1;
        resetn = 1'b0;
        osc_indicator = 1'b0;
        model = '{`RST_FAST_LOCK, `RST_PUMP, `RST_FEEDBACK, `RST_CONTROL, `RST_OSC, `RST_RF_DIV};
        repeat (3) @(posedge clock);
        #1;
        chk_out();
        resetn = 1'b1;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rnd = $urandom(32'h10D652AE);
        do_reset();
        read_all();
        // All ones everywhere but control bit 6: reserved bits must stay clear
        for (int i = 0; i < 6; i++) wr_reg(i, 8'hFF);
        settle();
        chk_out();
        read_all();
        // Every pump mode
        for (int m = 0; m < 4; m++) begin
            wr_reg(3, m[7:0]);
            settle();
            chk_out();
        end
        // Prescaler words on both sides of each limit
        for (int k = 0; k < 8; k++) begin
            wr_reg(2, div_tab[k]);
            settle();
            chk_out();
        end
        // Calibration start is held, never cleared by the block
        wr_reg(4, 8'h01);
        repeat (20) @(posedge clock);
        settle();
        chk_out();
        wr_reg(4, 8'h00);
        for (int k = 0; k < 3; k++) begin
            osc_indicator = k[0];
            settle();
            chk_out();
        end
        wr_reg(4, 8'h04);
        settle();
        chk_out();
        // Unmapped places: writes vanish and reads give zero
        for (int k = 0; k < 4; k++) begin
            bus_wr(bad_tab[k], 8'hFF);
            bus_rd(bad_tab[k], 1'b0, 8'h00, v);
            cmp_byte(v, 8'h00, "unmapped read");
        end
        settle();
        chk_out();
        // Read and write in one cycle return the old value
        bus_rd(addr_tab[1], 1'b1, ~model[1], v);
        cmp_byte(v, model[1], "read during write");
        model[1] = ~model[1];
        // Random traffic with a moving indicator
        for (int k = 0; k < 200; k++) begin
            int i;
            i = $urandom_range(5);
            osc_indicator = 1'($urandom_range(1));
            wr_reg(i, 8'($urandom));
            settle();
            chk_out();
            bus_rd(addr_tab[i], 1'b0, 8'h00, v);
            cmp_byte(v, model[i], "random read");
        end
        // Second reset in mid-run
        do_reset();
        read_all();
        tally_and_finish();
    end
endmodule
